// >>> timer8_pkg.sv
// What this block does
// - With sync hold set, written prescaler reset bits stay set, halting timers on internal clock sources.
// - Clearing sync hold clears held prescaler resets so timers start together.
// - Counter value and compare value are 8-bit CPU read/write registers.
// - Each request shows as a flag, gated by its own mask bit.
// - Counter advances only on tick; source select zero stops it.
// - CPU may read and write the counter at any time.
// - A CPU counter write beats a same-cycle count or clear.
// - Each tick clears, increments or decrements by one per mode and direction.
// - BOTTOM is counter zero, MAX is counter 255.
// - TOP is 255 or the compare value depending on mode.
// - Waveform mode selects sequence; overflow flag set where mode says.
// - Equal counter and compare gives match; flag set on following tick.
// - Compare request while flag, enable and global enable are all one.
// - Compare flag clears on service or on writing one; zero is ignored.
// - Compare output follows match per mode and action, using MAX and BOTTOM.
// - Compare value double-buffered in PWM modes, direct in normal and CTC.
// - Buffered compare value moves to active register only at TOP.
// - CPU compare accesses go to buffer when buffered, else active register.
// - Force strobe in non-PWM modes acts like a match on the output.
// - Forced compare sets no flag and leaves the counter alone.
// - A counter write blocks any compare match on the next tick.
// - Mode 0 is normal wrapping count-up, mode 2 is clear-on-compare.
// - Action zero leaves the compare output untouched on a match.
// - Normal mode sets overflow in the cycle the counter becomes zero.
`default_nettype none
package timer8_pkg;
	////////////////////////////////////////////////////////////////////////
	// I/O register addresses
	localparam logic [5:0] SFIO_ADDR = 6'h20;
	localparam logic [5:0] OCR_ADDR  = 6'h23;
	localparam logic [5:0] CNT_ADDR  = 6'h24;
	localparam logic [5:0] CTL_ADDR  = 6'h25;
	localparam logic [5:0] FLAG_ADDR = 6'h36;
	localparam logic [5:0] MASK_ADDR = 6'h37;
	// Field positions
	localparam int HOLD_BIT = 7;
	localparam int FRST_BIT = 1;
	localparam int PSRS_BIT = 0;
	localparam int FOC_BIT  = 7;
	localparam int WGM0_BIT = 6;
	localparam int COM_LSB  = 4;
	localparam int WGM1_BIT = 3;
	localparam int CS_LSB   = 0;
	localparam int OCF_BIT  = 7;
	localparam int TOV_BIT  = 6;
	// Reset values and extremes
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BOTTOM_VAL = 8'h00;
	localparam logic [7:0] MAX_VAL    = 8'hFF;
	// Waveform modes
	localparam logic [1:0] WM_NORMAL = 2'h0;
	localparam logic [1:0] WM_PCPWM  = 2'h1;
	localparam logic [1:0] WM_CTC    = 2'h2;
	localparam logic [1:0] WM_FAST   = 2'h3;
	// Compare output actions
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;
	// Prescaler tap widths: divide by 8, 64, 256, 1024
	localparam int DIV_BITS = 10;
	localparam int TAP8     = 3;
	localparam int TAP64    = 6;
	localparam int TAP256   = 8;
	////////////////////////////////////////////////////////////////////////
	// CPU I/O bus request
	typedef struct packed {
		logic [5:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} io_req_s;
endpackage : timer8_pkg
`default_nettype wire

// >>> edge_sync.sv
`default_nettype none
module edge_sync (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      rise,
	output logic      fall
);
	logic meta_q, sync_q, last_q;

	// Two stages before use; only the second and third feed the edge logic
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign rise = sync_q & ~last_q;
	assign fall = ~sync_q & last_q;
endmodule : edge_sync
`default_nettype wire

// >>> tick_source.sv
`default_nettype none
module tick_source (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       presc_clear,
	input  wire logic [2:0] clk_sel,
	input  wire logic       ext_rise,
	input  wire logic       ext_fall,
	output logic            tick
);
	logic [timer8_pkg::DIV_BITS-1:0] div_q, div_d;

	// Held prescaler reset freezes the divider at zero
	always_comb begin
		div_d = presc_clear ? '0 : div_q + 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	// One-cycle enable; internal sources halt while the reset is held
	always_comb begin
		case (clk_sel)
			3'h1: tick = !presc_clear;
			3'h2: tick = !presc_clear && (&div_q[timer8_pkg::TAP8-1:0]);
			3'h3: tick = !presc_clear && (&div_q[timer8_pkg::TAP64-1:0]);
			3'h4: tick = !presc_clear && (&div_q[timer8_pkg::TAP256-1:0]);
			3'h5: tick = !presc_clear && (&div_q);
			3'h6: tick = ext_fall;
			3'h7: tick = ext_rise;
			default: tick = 1'b0;
		endcase
	end
endmodule : tick_source
`default_nettype wire

// >>> timer8_counter_compare_unit.sv
`default_nettype none
module timer8_counter_compare_unit (
	input  wire logic                 mclk,
	input  wire logic                 rst_b,
	input  wire timer8_pkg::io_req_s  io_req,
	input  wire logic                 global_irq_enable,
	input  wire logic                 compare_irq_ack,
	input  wire logic                 overflow_irq_ack,
	input  wire logic                 external_count_pin,
	output logic [7:0]                io_rdata,
	output logic                      compare_output_pin,
	output logic                      compare_irq,
	output logic                      overflow_irq,
	output logic                      first_timer_prescaler_reset,
	output logic                      shared_prescaler_reset
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic       hold_q, hold_d, frst_q, frst_d, psrs_q, psrs_d;
	logic [2:0] cs_q, cs_d;
	logic [1:0] wgm_q, wgm_d, com_q, com_d;
	logic       cie_q, cie_d, oie_q, oie_d;
	logic [7:0] cnt_q, cnt_d, ocr_q, ocr_d, buf_q, buf_d;
	logic       up_q, up_d, block_q, block_d;
	logic       ocf_q, ocf_d, tov_q, tov_d, oc_q, oc_d;
	logic       cirq_q, cirq_d, oirq_q, oirq_d;
	logic [7:0] rdata_q, rdata_d;
	logic       wr_sf, wr_ctl, wr_cnt, wr_ocr, wr_flag, wr_mask;
	logic       force_now, pwm, tick, ext_rise, ext_fall;
	logic       at_max, at_bottom, at_top, match, cmp_ev, ovf_ev;
	logic [7:0] top_val, wd;

	////////////////////////////////////////////////////////////////////////
	// Address decode
	assign wd = io_req.wdata;
	always_comb begin
		wr_sf   = 1'b0;
		wr_ctl  = 1'b0;
		wr_cnt  = 1'b0;
		wr_ocr  = 1'b0;
		wr_flag = 1'b0;
		wr_mask = 1'b0;
		if (!io_req.wr) begin
			wr_sf = 1'b0;
		end else if (io_req.addr == timer8_pkg::SFIO_ADDR) begin
			wr_sf = 1'b1;
		end else if (io_req.addr == timer8_pkg::CTL_ADDR) begin
			wr_ctl = 1'b1;
		end else if (io_req.addr == timer8_pkg::CNT_ADDR) begin
			wr_cnt = 1'b1;
		end else if (io_req.addr == timer8_pkg::OCR_ADDR) begin
			wr_ocr = 1'b1;
		end else if (io_req.addr == timer8_pkg::FLAG_ADDR) begin
			wr_flag = 1'b1;
		end else if (io_req.addr == timer8_pkg::MASK_ADDR) begin
			wr_mask = 1'b1;
		end
	end

	// Force strobe is never stored, so it reads back as zero
	assign force_now = wr_ctl && wd[timer8_pkg::FOC_BIT];
	assign pwm = (wgm_q == timer8_pkg::WM_PCPWM) || (wgm_q == timer8_pkg::WM_FAST);

	////////////////////////////////////////////////////////////////////////
	// Tick generation
	edge_sync u_pin (
		.mclk (mclk),
		.rst_b(rst_b),
		.pin  (external_count_pin),
		.rise (ext_rise),
		.fall (ext_fall)
	);

	tick_source u_tick (
		.mclk       (mclk),
		.rst_b      (rst_b),
		.presc_clear(psrs_q),
		.clk_sel    (cs_q),
		.ext_rise   (ext_rise),
		.ext_fall   (ext_fall),
		.tick       (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Special function and control registers
	// A reset bit written without hold lives one cycle; with hold it stays
	always_comb begin
		hold_d = hold_q;
		frst_d = frst_q & hold_q;
		psrs_d = psrs_q & hold_q;
		cs_d   = cs_q;
		wgm_d  = wgm_q;
		com_d  = com_q;
		cie_d  = cie_q;
		oie_d  = oie_q;
		if (wr_sf) begin
			hold_d = wd[timer8_pkg::HOLD_BIT];
			frst_d = wd[timer8_pkg::FRST_BIT] | (frst_q & wd[timer8_pkg::HOLD_BIT]);
			psrs_d = wd[timer8_pkg::PSRS_BIT] | (psrs_q & wd[timer8_pkg::HOLD_BIT]);
		end
		if (wr_ctl) begin
			cs_d  = wd[timer8_pkg::CS_LSB+:3];
			wgm_d = {wd[timer8_pkg::WGM1_BIT], wd[timer8_pkg::WGM0_BIT]};
			com_d = wd[timer8_pkg::COM_LSB+:2];
		end
		if (wr_mask) begin
			cie_d = wd[timer8_pkg::OCF_BIT];
			oie_d = wd[timer8_pkg::TOV_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hold_q <= 1'b0;
			frst_q <= 1'b0;
			psrs_q <= 1'b0;
			cs_q   <= 3'h0;
			wgm_q  <= timer8_pkg::WM_NORMAL;
			com_q  <= timer8_pkg::ACT_NONE;
			cie_q  <= 1'b0;
			oie_q  <= 1'b0;
		end else begin
			hold_q <= hold_d;
			frst_q <= frst_d;
			psrs_q <= psrs_d;
			cs_q   <= cs_d;
			wgm_q  <= wgm_d;
			com_q  <= com_d;
			cie_q  <= cie_d;
			oie_q  <= oie_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counter unit
	assign at_max    = cnt_q == timer8_pkg::MAX_VAL;
	assign at_bottom = cnt_q == timer8_pkg::BOTTOM_VAL;
	assign top_val   = (wgm_q == timer8_pkg::WM_CTC) ? ocr_q : timer8_pkg::MAX_VAL;
	assign at_top    = cnt_q == top_val;
	assign match     = cnt_q == ocr_q;

	// CPU write wins over the tick and arms the one-tick match block
	always_comb begin
		cnt_d   = cnt_q;
		up_d    = up_q;
		block_d = block_q;
		cmp_ev  = 1'b0;
		ovf_ev  = 1'b0;
		if (tick) begin
			block_d = 1'b0;
			cmp_ev  = match && !block_q;
			case (wgm_q)
				timer8_pkg::WM_CTC: begin
					cnt_d  = at_top ? timer8_pkg::BOTTOM_VAL : cnt_q + 8'h01;
					ovf_ev = at_max;
					up_d   = 1'b1;
				end
				timer8_pkg::WM_PCPWM: begin
					if (up_q) begin
						up_d  = !at_max;
						cnt_d = at_max ? cnt_q - 8'h01 : cnt_q + 8'h01;
					end else begin
						up_d   = at_bottom;
						ovf_ev = at_bottom;
						cnt_d  = at_bottom ? cnt_q + 8'h01 : cnt_q - 8'h01;
					end
				end
				default: begin
					cnt_d  = cnt_q + 8'h01;
					ovf_ev = at_max;
					up_d   = 1'b1;
				end
			endcase
		end
		if (wr_cnt) begin
			cnt_d   = wd;
			ovf_ev  = 1'b0;
			block_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q   <= timer8_pkg::RESET_BYTE;
			up_q    <= 1'b1;
			block_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			up_q    <= up_d;
			block_q <= block_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare register with PWM double buffer
	// Loading only at TOP keeps every PWM period whole
	always_comb begin
		ocr_d = ocr_q;
		buf_d = buf_q;
		if (wr_ocr) begin
			buf_d = wd;
			if (!pwm) begin
				ocr_d = wd;
			end
		end
		if (pwm && tick && at_max) begin
			ocr_d = buf_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ocr_q <= timer8_pkg::RESET_BYTE;
			buf_q <= timer8_pkg::RESET_BYTE;
		end else begin
			ocr_q <= ocr_d;
			buf_q <= buf_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flags, requests and waveform output
	// A set in the clearing cycle wins so no event is lost
	always_comb begin
		ocf_d = ocf_q;
		tov_d = tov_q;
		oc_d  = oc_q;
		if ((wr_flag && wd[timer8_pkg::OCF_BIT]) || compare_irq_ack) begin
			ocf_d = 1'b0;
		end
		if ((wr_flag && wd[timer8_pkg::TOV_BIT]) || overflow_irq_ack) begin
			tov_d = 1'b0;
		end
		if (cmp_ev) begin
			ocf_d = 1'b1;
		end
		if (ovf_ev) begin
			tov_d = 1'b1;
		end
		if (!pwm) begin
			if (cmp_ev || force_now) begin
				case (force_now ? wd[timer8_pkg::COM_LSB+:2] : com_q) // A force acts with the action written alongside it
					timer8_pkg::ACT_TOGGLE: oc_d = !oc_q;
					timer8_pkg::ACT_CLEAR:  oc_d = 1'b0;
					timer8_pkg::ACT_SET:    oc_d = 1'b1;
					default:                oc_d = oc_q;
				endcase
			end
		end else if (com_q[1]) begin
			if (wgm_q == timer8_pkg::WM_FAST) begin
				if (cmp_ev) begin
					oc_d = com_q[0];
				end else if (tick && at_max) begin
					oc_d = !com_q[0];
				end
			end else if (cmp_ev) begin
				oc_d = up_q ? com_q[0] : !com_q[0];
			end
		end
		cirq_d = ocf_q && cie_q && global_irq_enable;
		oirq_d = tov_q && oie_q && global_irq_enable;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ocf_q  <= 1'b0;
			tov_q  <= 1'b0;
			oc_q   <= 1'b0;
			cirq_q <= 1'b0;
			oirq_q <= 1'b0;
		end else begin
			ocf_q  <= ocf_d;
			tov_q  <= tov_d;
			oc_q   <= oc_d;
			cirq_q <= cirq_d;
			oirq_q <= oirq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, held until the next read; unmapped reads give zero
	always_comb begin
		rdata_d = rdata_q;
		if (io_req.rd) begin
			if (io_req.addr == timer8_pkg::SFIO_ADDR) begin
				rdata_d = {hold_q, 5'h00, frst_q, psrs_q};
			end else if (io_req.addr == timer8_pkg::CTL_ADDR) begin
				rdata_d = {1'b0, wgm_q[0], com_q, wgm_q[1], cs_q};
			end else if (io_req.addr == timer8_pkg::CNT_ADDR) begin
				rdata_d = cnt_q;
			end else if (io_req.addr == timer8_pkg::OCR_ADDR) begin
				rdata_d = pwm ? buf_q : ocr_q;
			end else if (io_req.addr == timer8_pkg::FLAG_ADDR) begin
				rdata_d = {ocf_q, tov_q, 6'h00};
			end else if (io_req.addr == timer8_pkg::MASK_ADDR) begin
				rdata_d = {cie_q, oie_q, 6'h00};
			end else begin
				rdata_d = 8'h00;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign io_rdata                    = rdata_q;
	assign compare_output_pin          = oc_q;
	assign compare_irq                 = cirq_q;
	assign overflow_irq                = oirq_q;
	assign first_timer_prescaler_reset = frst_q;
	assign shared_prescaler_reset      = psrs_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence s_cnt_write;
		wr_cnt;
	endsequence
	sequence s_blocked_tick;
		block_q && tick && !ocf_q && !compare_irq_ack;
	endsequence

	a_hold_keeps_reset: assert property (hold_q && psrs_q && !wr_sf |=> psrs_q)
		else $error("held prescaler reset dropped");
	a_hold_release: assert property (hold_q && wr_sf && wd == 8'h00 |=> !psrs_q && !frst_q)
		else $error("prescaler reset not cleared on release");
	a_stop_no_count: assert property (cs_q == 3'h0 && !wr_cnt |=> cnt_q == $past(cnt_q))
		else $error("counter moved while stopped");
	a_cpu_write_wins: assert property (s_cnt_write |=> cnt_q == $past(wd) ##1 !block_q || !tick)
		else $error("counter write lost");
	a_normal_step: assert property (tick && wgm_q == timer8_pkg::WM_NORMAL && !wr_cnt
		|=> cnt_q == 8'($past(cnt_q) + 8'h01))
		else $error("normal mode did not step by one");
	a_normal_ovf: assert property (tick && wgm_q == timer8_pkg::WM_NORMAL && at_max && !wr_cnt
		|=> tov_q && cnt_q == 8'h00)
		else $error("overflow not set as counter wrapped");
	a_match_flag: assert property (tick && match && !block_q |=> ocf_q)
		else $error("match did not set flag");
	a_write_blocks: assert property (s_blocked_tick |=> !ocf_q)
		else $error("match not blocked after counter write");
	a_irq_gating: assert property (ocf_q && cie_q && global_irq_enable |=> compare_irq)
		else $error("compare request not raised");
	a_ack_clears: assert property (ocf_q && compare_irq_ack && !cmp_ev |=> !ocf_q)
		else $error("flag not cleared on service");
	a_force_toggle: assert property (force_now && !pwm && wd[timer8_pkg::COM_LSB+:2] == timer8_pkg::ACT_TOGGLE
		&& !cmp_ev && !compare_irq_ack
		|=> oc_q != $past(oc_q) && ocf_q == $past(ocf_q))
		else $error("forced compare misbehaved");
	a_direct_write: assert property (!pwm && wr_ocr |=> ocr_q == $past(wd))
		else $error("direct compare write missing");
	a_buffer_holds: assert property (pwm && wr_ocr && !(tick && at_max) |=> ocr_q == $past(ocr_q))
		else $error("buffered compare changed early");
	a_ctc_clear: assert property (tick && wgm_q == timer8_pkg::WM_CTC && at_top && !wr_cnt
		|=> cnt_q == 8'h00)
		else $error("clear-on-compare did not clear");
endmodule : timer8_counter_compare_unit
`default_nettype wire

// >>> cpu_bus_model.sv
`default_nettype none
module cpu_bus_model (
	input  wire logic               mclk,
	input  wire logic [7:0]         io_rdata,
	output var timer8_pkg::io_req_s io_req,
	output var logic                global_irq_enable,
	output var logic                compare_irq_ack,
	output var logic                overflow_irq_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////
	// Bus idle and interrupts shut until the bench opens them
	initial begin
		io_req = '0;
		global_irq_enable = 1'b0;
		compare_irq_ack = 1'b0;
		overflow_irq_ack = 1'b0;
	end
	// Write strobe lasts one cycle, so the block takes it exactly once
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge mclk);
		io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge mclk);
		io_req <= '0;
	endtask : wr
	// Read data is registered, so it is sampled just after the taking edge
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge mclk);
		io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
		@(posedge mclk);
		io_req <= '0;
		#1 d = io_rdata;
	endtask : rd
	// Interrupt service acknowledge, one cycle wide
	task automatic ack(input logic ovf);
		@(posedge mclk);
		if (ovf) overflow_irq_ack <= 1'b1;
		else compare_irq_ack <= 1'b1;
		@(posedge mclk);
		overflow_irq_ack <= 1'b0;
		compare_irq_ack <= 1'b0;
	endtask : ack
	// Status register global interrupt enable
	task automatic gie(input logic v);
		@(posedge mclk);
		global_irq_enable <= v;
	endtask : gie
endmodule : cpu_bus_model
`default_nettype wire

// >>> test_timer8_counter_compare_unit.sv
`default_nettype none
module test_timer8_counter_compare_unit;
	timeunit 1ns;
	timeprecision 1ps;
	logic                mclk;
	logic                rst_b;
	timer8_pkg::io_req_s io_req;
	logic                global_irq_enable;
	logic                compare_irq_ack;
	logic                overflow_irq_ack;
	logic                external_count_pin;
	logic [7:0]          io_rdata;
	logic                compare_output_pin;
	logic                compare_irq;
	logic                overflow_irq;
	logic                first_timer_prescaler_reset;
	logic                shared_prescaler_reset;
	int                  fails;
	int                  checks_done;
	int                  cycles;
	int                  n;
	logic [7:0]          v;
	////////////////////////////////////////////////////////////////////////
	timer8_counter_compare_unit i_dut (
		.mclk(mclk), .rst_b(rst_b), .io_req(io_req), .global_irq_enable(global_irq_enable),
		.compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack),
		.external_count_pin(external_count_pin), .io_rdata(io_rdata),
		.compare_output_pin(compare_output_pin), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
		.first_timer_prescaler_reset(first_timer_prescaler_reset),
		.shared_prescaler_reset(shared_prescaler_reset)
	);
	cpu_bus_model i_cpu (
		.mclk(mclk), .io_rdata(io_rdata), .io_req(io_req), .global_irq_enable(global_irq_enable),
		.compare_irq_ack(compare_irq_ack), .overflow_irq_ack(overflow_irq_ack)
	);
	////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard: the whole run needs far fewer cycles than this
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fails = fails + 1;
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic print_verdict();
		if (fails == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////////////////
	// Counter, compare and flags clear on reset; unmapped places neither store nor answer
	task automatic t_reset();
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("counter reset", 8'h00, v);
		i_cpu.rd(timer8_pkg::OCR_ADDR, v); chk("compare reset", 8'h00, v);
		i_cpu.rd(timer8_pkg::FLAG_ADDR, v); chk("flags reset", 8'h00, v);
		i_cpu.wr(6'h01, 8'hFF);
		i_cpu.rd(6'h01, v); chk("unmapped read", 8'h00, v);
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'hA5);
		i_cpu.wr(timer8_pkg::OCR_ADDR, 8'h5A);
		i_cpu.wr(timer8_pkg::MASK_ADDR, 8'hC0);
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("counter rw", 8'hA5, v);
		i_cpu.rd(timer8_pkg::OCR_ADDR, v); chk("compare rw", 8'h5A, v);
		i_cpu.rd(timer8_pkg::MASK_ADDR, v); chk("mask rw", 8'hC0, v);
	endtask : t_reset
	// Held prescaler reset freezes the counter until the hold is dropped
	task automatic t_sync();
		i_cpu.wr(timer8_pkg::SFIO_ADDR, 8'h01);
		#1 chk("pulse high", 8'h01, {7'h00, shared_prescaler_reset});
		cyc(1); chk("pulse one cycle", 8'h00, {7'h00, shared_prescaler_reset});
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h00);
		i_cpu.wr(timer8_pkg::SFIO_ADDR, 8'h83);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h01);
		cyc(10); chk("held resets", 8'h03, {6'h00, first_timer_prescaler_reset, shared_prescaler_reset});
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("halted counter", 8'h00, v);
		i_cpu.wr(timer8_pkg::SFIO_ADDR, 8'h00);
		#1 chk("released resets", 8'h00, {6'h00, first_timer_prescaler_reset, shared_prescaler_reset});
		cyc(4);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h00);
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("counter started", 8'h01, {7'h00, v !== 8'h00});
	endtask : t_sync
	// Rising pin edges, synchronised, each count once
	task automatic t_ext();
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h00);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h07);
		repeat (4) begin
			@(posedge mclk) external_count_pin <= 1'b1;
			repeat (5) @(posedge mclk);
			external_count_pin <= 1'b0;
			repeat (5) @(posedge mclk);
		end
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("pin edge count", 8'h04, v);
		// Falling-edge source: only the two falls count
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h06);
		repeat (2) begin
			@(posedge mclk) external_count_pin <= 1'b1;
			repeat (5) @(posedge mclk);
			external_count_pin <= 1'b0;
			repeat (5) @(posedge mclk);
		end
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("falling edge count", 8'h06, v);
		// Sixteen ticking edges hold exactly two divide-by-8 pulses, whatever the divider phase
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h00);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h02);
		cyc(14);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h00);
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("divide by 8", 8'h02, v);
	endtask : t_ext
	// Normal mode wraps past 0xFF and raises the overflow request
	task automatic t_ovf();
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h00);
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'hFD);
		i_cpu.wr(timer8_pkg::FLAG_ADDR, 8'hC0);
		i_cpu.gie(1'b1);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h01);
		n = 0;
		while (overflow_irq !== 1'b1 && n < 20) begin
			cyc(1);
			n++;
		end
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h00);
		chk("overflow request", 8'h01, {7'h00, overflow_irq});
		i_cpu.ack(1'b1);
		cyc(2); chk("overflow serviced", 8'h00, {7'h00, overflow_irq});
	endtask : t_ovf
	// Clear-on-compare with toggle: the output toggles every compare plus one ticks
	task automatic t_ctc();
		i_cpu.wr(timer8_pkg::OCR_ADDR, 8'h05);
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h00);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h19);
		for (int k = 0; k < 2; k++) begin
			v[0] = compare_output_pin;
			n = 0;
			while (compare_output_pin === v[0] && n < 40) begin
				cyc(1);
				n++;
			end
		end
		chk("toggle period", 8'h06, n[7:0]);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h18);
		cyc(2); chk("compare request", 8'h01, {7'h00, compare_irq});
		i_cpu.gie(1'b0);
		cyc(2); chk("global gate", 8'h00, {7'h00, compare_irq});
		i_cpu.gie(1'b1);
		i_cpu.wr(timer8_pkg::FLAG_ADDR, 8'h00);
		cyc(2); chk("zero write keeps flag", 8'h01, {7'h00, compare_irq});
		i_cpu.ack(1'b0);
		cyc(2); chk("serviced flag", 8'h00, {7'h00, compare_irq});
	endtask : t_ctc
	// A counter write suppresses the match on the next tick
	task automatic t_block();
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h00);
		i_cpu.wr(timer8_pkg::OCR_ADDR, 8'h10);
		i_cpu.wr(timer8_pkg::FLAG_ADDR, 8'hC0);
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h10);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h01);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h00);
		i_cpu.rd(timer8_pkg::FLAG_ADDR, v); chk("blocked match", 8'h00, v);
	endtask : t_block
	// Forced compare moves only the output; strobe reads back as zero
	task automatic t_force();
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h44);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'hA0);
		cyc(2); chk("forced clear", 8'h00, {7'h00, compare_output_pin});
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'hB0);
		cyc(2); chk("forced set", 8'h01, {7'h00, compare_output_pin});
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h90);
		cyc(2); chk("forced toggle", 8'h00, {7'h00, compare_output_pin});
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h80);
		cyc(2); chk("no action", 8'h00, {7'h00, compare_output_pin});
		i_cpu.rd(timer8_pkg::CTL_ADDR, v); chk("strobe reads zero", 8'h00, v);
		i_cpu.rd(timer8_pkg::FLAG_ADDR, v); chk("force sets no flag", 8'h00, v);
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("force keeps counter", 8'h44, v);
	endtask : t_force
	// In fast PWM a compare write lands in the buffer; the old value still matches
	task automatic t_pwm();
		i_cpu.wr(timer8_pkg::OCR_ADDR, 8'h20);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h48);
		i_cpu.wr(timer8_pkg::OCR_ADDR, 8'h80);
		i_cpu.rd(timer8_pkg::OCR_ADDR, v); chk("buffer read", 8'h80, v);
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h1E);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h49);
		cyc(6);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h48);
		i_cpu.rd(timer8_pkg::FLAG_ADDR, v); chk("active kept", 8'h80, v);
	endtask : t_pwm
	// Phase-correct PWM turns down at MAX, turns up at BOTTOM and flags overflow there
	task automatic t_pcpwm();
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'hFD);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h41);
		cyc(5);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h40);
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("down after MAX", 8'hFA, v);
		i_cpu.wr(timer8_pkg::FLAG_ADDR, 8'hC0);
		i_cpu.wr(timer8_pkg::CNT_ADDR, 8'h02);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h41);
		cyc(5);
		i_cpu.wr(timer8_pkg::CTL_ADDR, 8'h40);
		i_cpu.rd(timer8_pkg::CNT_ADDR, v); chk("up after BOTTOM", 8'h05, v);
		i_cpu.rd(timer8_pkg::FLAG_ADDR, v); chk("bottom overflow", 8'h40, v);
	endtask : t_pcpwm
	////////////////////////////////////////////////////////////////////////
	// Reset for 12 cycles, then each scenario in turn
	initial begin
		fails = 0;
		checks_done = 0;
		cycles = 0;
		rst_b = 1'b0;
		external_count_pin = 1'b0;
		repeat (12) @(posedge mclk);
		rst_b <= 1'b1;
		t_reset();
		t_sync();
		t_ext();
		t_ovf();
		t_ctc();
		t_block();
		t_force();
		t_pwm();
		t_pcpwm();
		print_verdict();
	end
endmodule : test_timer8_counter_compare_unit
`default_nettype wire
